// >>> include/cotp_pkg.sv
// constants and types shared by the operand transfer primitive engine
`default_nettype none

package cotp_pkg;

  // ----------------------------------------
  // register map (byte offsets, 8-bit window)
  // ----------------------------------------
  localparam logic [7:0] OFS_PRIM      = 8'h00;
  localparam logic [7:0] OFS_CMD       = 8'h04;
  localparam logic [7:0] OFS_STAT      = 8'h08;
  localparam logic [7:0] OFS_SR        = 8'h0C;
  localparam logic [7:0] OFS_ASP       = 8'h10;
  localparam logic [2:0] OFS_CTRL_TOP  = 3'h1;   // adr[7:5], block at 0x20..0x3C
  localparam logic [1:0] OFS_RF_TOP    = 2'h1;   // adr[7:6], block at 0x40..0x7C

  localparam int unsigned CMD_START_BIT = 0;
  localparam int unsigned CMD_COND_BIT  = 1;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_DONE_BIT = 1;
  localparam int unsigned STAT_VIOL_BIT = 2;

  localparam int unsigned SR_SUPER_BIT  = 13;
  localparam logic [15:0] SR_RST        = 16'h2000;

  // ----------------------------------------
  // primitive word fields and patterns
  // ----------------------------------------
  localparam int unsigned PRIM_CA_BIT   = 15;
  localparam int unsigned PRIM_DR_BIT   = 13;
  localparam int unsigned PRIM_DA_BIT   = 3;
  localparam logic [7:0]  PAT_SREG      = 8'h60;     // bits 12..5
  localparam logic [12:0] PAT_CREG      = 13'h0D00;  // bits 12..0
  localparam logic [4:0]  PAT_TAKE      = 5'h05;     // bits 12..8
  localparam logic [4:0]  PAT_TOS       = 5'h0E;     // bits 12..8

  // ----------------------------------------
  // interface register addresses, function codes, sizes
  // ----------------------------------------
  localparam logic [31:0] CIR_OPERAND   = 32'h0000_0010;
  localparam logic [31:0] CIR_REGSEL    = 32'h0000_0014;
  localparam logic [31:0] CIR_OPADDR    = 32'h0000_0018;
  localparam logic [2:0]  FC_USER_DATA  = 3'h1;
  localparam logic [2:0]  FC_SUP_DATA   = 3'h5;
  localparam logic [2:0]  FC_CPU_SPACE  = 3'h7;
  localparam logic [2:0]  SIZE_LONG     = 3'h4;
  localparam logic [2:0]  SIZE_WORD     = 3'h2;
  localparam logic [7:0]  LEN_BYTE      = 8'h01;
  localparam logic [7:0]  LEN_WORD      = 8'h02;
  localparam logic [7:0]  LEN_LONG      = 8'h04;
  localparam logic [7:0]  STACK_BYTE_STEP = 8'h02;
  localparam logic [3:0]  RF_IDX_ASP    = 4'hF;

  // ----------------------------------------
  // control register select codes and slots
  // ----------------------------------------
  localparam logic [11:0] SEL_SFC  = 12'h000;
  localparam logic [11:0] SEL_DFC  = 12'h001;
  localparam logic [11:0] SEL_CACHE_CONTROL_REG = 12'h002;
  localparam logic [11:0] SEL_USP  = 12'h800;
  localparam logic [11:0] SEL_VBR  = 12'h801;
  localparam logic [11:0] SEL_CACHE_ADDRESS_REG = 12'h802;
  localparam logic [11:0] SEL_MSP  = 12'h803;
  localparam logic [11:0] SEL_ISP  = 12'h804;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'b0000001,
    ST_DECODE = 7'b0000010,
    ST_GETADR = 7'b0000100,
    ST_GETSEL = 7'b0001000,
    ST_FETCH  = 7'b0010000,
    ST_STORE  = 7'b0100000,
    ST_FINISH = 7'b1000000
  } cotp_state_t;

endpackage

`default_nettype wire

// >>> core/cotp_regfile.sv
// data and address register file with registered read data
`default_nettype none

module cotp_regfile #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     we_i,
  input  wire logic [$clog2(DEPTH)-1:0] addr_i,
  input  wire logic [WIDTH-1:0]         wdata_i,
  output logic      [WIDTH-1:0]         rdata_o
);

  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  if (DEPTH != 16 || WIDTH != 32)
  begin : g_bad
    $error("cotp_regfile serves sixteen 32-bit registers only");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0]            rdata;
  } cotp_rf_t;

  cotp_rf_t state_ff;
  cotp_rf_t nxt_state;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    // read before write: a same-cycle write shows up on the next read
    nxt_state.rdata = state_ff.mem[addr_i];
    if (we_i)
    begin
      nxt_state.mem[addr_i] = wdata_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign rdata_o = state_ff.rdata;

endmodule

`default_nettype wire

// >>> core/cotp_engine.sv
// main-processor engine for the four operand transfer response primitives
//
// Notes on behaviour
// - all four primitives accepted in general and conditional category instructions
// - conditional category with come-again flag clear raises protocol violation
// - take-address length field may be any value 0 to 255
// - take-address first reads 32-bit address from operand address interface register
// - take-address parts move as long words to ascending addresses; direction chooses
// - leftover tail of one, two or three bytes moves in one transfer
// - supplied-address cycles carry supervisor or user data function code per status bit
// - top-of-stack lengths other than one, two or four raise protocol violation
// - direction clear pops from active stack post-increment; byte pop adds two
// - direction set pushes onto active stack pre-decrement; byte push subtracts two
// - single register: selector zero picks data register, one picks address register
// - single register copied to operand register when clear, loaded when set
// - control register primitive moves exactly one long word
// - control register primitive reads select code from register select interface register
// - select codes decoded ignoring top hex digit into eight control registers
// - invalid select code raises protocol violation, no data moves
// - direction clear means toward coprocessor, set means toward main processor
// - control register written to operand register when clear, loaded when set
`default_nettype none

module cotp_engine #(
  parameter int unsigned ADR_W    = 8,
  parameter logic [31:0] CIR_BASE = 32'h0000_0000
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  output logic                  bus_req_o,
  output logic                  bus_we_o,
  output logic      [31:0]      bus_addr_o,
  output logic      [2:0]       bus_size_o,
  output logic      [2:0]       bus_fc_o,
  output logic      [31:0]      bus_wdata_o,
  input  wire logic [31:0]      bus_rdata_i,
  input  wire logic             bus_ack_i
);

  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  if (ADR_W != 8)
  begin : g_bad
    $error("cotp_engine decodes an 8-bit register window only");
  end

  typedef struct packed {
    cotp_pkg::cotp_state_t st;
    logic [15:0]           prim;
    logic                  cond;
    logic [15:0]           sr;
    logic [31:0]           asp;
    logic [7:0][31:0]      ctrl;
    logic                  done;
    logic                  viol;
    logic [31:0]           addr;
    logic [7:0]            rem;
    logic [2:0]            csel;
    logic [31:0]           hold;
    logic                  pend;
    logic                  req;
    logic                  we;
    logic [31:0]           baddr;
    logic [2:0]            size;
    logic [2:0]            fc;
    logic [31:0]           wdata;
    logic                  wb_ack;
    logic [31:0]           wb_dat;
    logic                  rd_rf;
  } cotp_regs_t;

  cotp_regs_t  state_ff;
  cotp_regs_t  nxt_state;
  logic        rf_we;
  logic [3:0]  rf_addr;
  logic [31:0] rf_wdata;
  logic [31:0] rf_rdata;

  function automatic logic [31:0] cotp_merge(input logic [31:0] old, input logic [31:0] din,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[8*i +: 8] = din[8*i +: 8];
      end
    end
    return r;
  endfunction

  cotp_regfile #(
    .WIDTH (32),
    .DEPTH (16)
  ) u_rf (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .we_i    (rf_we),
    .addr_i  (rf_addr),
    .wdata_i (rf_wdata),
    .rdata_o (rf_rdata)
  );

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  logic        busy;
  logic        dr;
  logic [7:0]  len;
  logic        is_sreg;
  logic        is_creg;
  logic        is_take;
  logic        is_tos;
  logic [7:0]  step;
  logic [2:0]  part;
  logic [2:0]  dfc;
  logic        hit;
  logic        sreg_asp;

  always_comb
  begin
    busy     = (state_ff.st != cotp_pkg::ST_IDLE);
    dr       = state_ff.prim[cotp_pkg::PRIM_DR_BIT];
    len      = state_ff.prim[7:0];
    is_sreg  = (state_ff.prim[12:5] == cotp_pkg::PAT_SREG);
    is_creg  = (state_ff.prim[12:0] == cotp_pkg::PAT_CREG);
    is_take  = (state_ff.prim[12:8] == cotp_pkg::PAT_TAKE);
    is_tos   = (state_ff.prim[12:8] == cotp_pkg::PAT_TOS);
    // byte moves keep the stack word aligned
    step     = (len == cotp_pkg::LEN_BYTE) ? cotp_pkg::STACK_BYTE_STEP : len;
    // long words first, then one odd tail
    part     = (state_ff.rem >= 8'h04) ? cotp_pkg::SIZE_LONG : state_ff.rem[2:0];
    dfc      = state_ff.sr[cotp_pkg::SR_SUPER_BIT] ? cotp_pkg::FC_SUP_DATA
                                                   : cotp_pkg::FC_USER_DATA;
    hit      = wb_cyc_i & wb_stb_i & ~state_ff.wb_ack;
    // address register seven is the active stack pointer
    sreg_asp = ({state_ff.prim[cotp_pkg::PRIM_DA_BIT], state_ff.prim[2:0]} == cotp_pkg::RF_IDX_ASP);
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    nxt_state        = state_ff;
    nxt_state.wb_ack = 1'b0;
    rf_we            = 1'b0;
    rf_addr          = wb_adr_i[5:2];
    rf_wdata         = wb_dat_i;

    // register bus; the file port belongs to the engine while busy
    if (hit)
    begin
      if (wb_adr_i[7:6] == cotp_pkg::OFS_RF_TOP)
      begin
        if (!busy)
        begin
          nxt_state.wb_ack = 1'b1;
          nxt_state.rd_rf  = 1'b1;
          rf_we            = wb_we_i & (&wb_sel_i);
        end
      end
      else
      begin
        nxt_state.wb_ack = 1'b1;
        nxt_state.rd_rf  = 1'b0;
        nxt_state.wb_dat = 32'h0000_0000;
        if (wb_adr_i == cotp_pkg::OFS_PRIM)
        begin
          nxt_state.wb_dat = {16'h0000, state_ff.prim};
          if (wb_we_i && !busy)
          begin
            nxt_state.prim = 16'(cotp_merge({16'h0000, state_ff.prim}, wb_dat_i, wb_sel_i));
          end
        end
        else if (wb_adr_i == cotp_pkg::OFS_CMD)
        begin
          nxt_state.wb_dat = {31'h0000_0000, state_ff.cond};
          if (wb_we_i && !busy && wb_sel_i[0] && wb_dat_i[cotp_pkg::CMD_START_BIT])
          begin
            nxt_state.cond = wb_dat_i[cotp_pkg::CMD_COND_BIT];
            nxt_state.done = 1'b0;
            nxt_state.viol = 1'b0;
            nxt_state.st   = cotp_pkg::ST_DECODE;
          end
        end
        else if (wb_adr_i == cotp_pkg::OFS_STAT)
        begin
          nxt_state.wb_dat[cotp_pkg::STAT_BUSY_BIT] = busy;
          nxt_state.wb_dat[cotp_pkg::STAT_DONE_BIT] = state_ff.done;
          nxt_state.wb_dat[cotp_pkg::STAT_VIOL_BIT] = state_ff.viol;
          if (wb_we_i && wb_sel_i[0])
          begin
            // write one to clear; a finishing engine below sets again and wins
            nxt_state.done = state_ff.done & ~wb_dat_i[cotp_pkg::STAT_DONE_BIT];
            nxt_state.viol = state_ff.viol & ~wb_dat_i[cotp_pkg::STAT_VIOL_BIT];
          end
        end
        else if (wb_adr_i == cotp_pkg::OFS_SR)
        begin
          nxt_state.wb_dat = {16'h0000, state_ff.sr};
          if (wb_we_i && !busy)
          begin
            nxt_state.sr = 16'(cotp_merge({16'h0000, state_ff.sr}, wb_dat_i, wb_sel_i));
          end
        end
        else if (wb_adr_i == cotp_pkg::OFS_ASP)
        begin
          nxt_state.wb_dat = state_ff.asp;
          if (wb_we_i && !busy)
          begin
            nxt_state.asp = cotp_merge(state_ff.asp, wb_dat_i, wb_sel_i);
          end
        end
        else if (wb_adr_i[7:5] == cotp_pkg::OFS_CTRL_TOP)
        begin
          nxt_state.wb_dat = state_ff.ctrl[wb_adr_i[4:2]];
          if (wb_we_i && !busy)
          begin
            nxt_state.ctrl[wb_adr_i[4:2]] = cotp_merge(state_ff.ctrl[wb_adr_i[4:2]], wb_dat_i, wb_sel_i);
          end
        end
      end
    end

    // engine
    case (state_ff.st)
      cotp_pkg::ST_IDLE:
      begin
        nxt_state.pend = 1'b0;
      end
      cotp_pkg::ST_DECODE:
      begin
        nxt_state.we   = 1'b0;
        nxt_state.fc   = cotp_pkg::FC_CPU_SPACE;
        nxt_state.size = cotp_pkg::SIZE_LONG;
        nxt_state.rem  = cotp_pkg::LEN_LONG;
        nxt_state.addr = state_ff.asp;
        if (!(is_sreg || is_creg || is_take || is_tos))
        begin
          nxt_state.viol = 1'b1;
          nxt_state.st   = cotp_pkg::ST_IDLE;
        end
        else if (state_ff.cond && !state_ff.prim[cotp_pkg::PRIM_CA_BIT])
        begin
          nxt_state.viol = 1'b1;
          nxt_state.st   = cotp_pkg::ST_IDLE;
        end
        else if (is_tos && len != cotp_pkg::LEN_BYTE && len != cotp_pkg::LEN_WORD && len != cotp_pkg::LEN_LONG)
        begin
          nxt_state.viol = 1'b1;
          nxt_state.st   = cotp_pkg::ST_IDLE;
        end
        else if (is_take)
        begin
          nxt_state.req   = 1'b1;
          nxt_state.baddr = CIR_BASE + cotp_pkg::CIR_OPADDR;
          nxt_state.st    = cotp_pkg::ST_GETADR;
        end
        else if (is_creg)
        begin
          nxt_state.req   = 1'b1;
          nxt_state.size  = cotp_pkg::SIZE_WORD;
          nxt_state.baddr = CIR_BASE + cotp_pkg::CIR_REGSEL;
          nxt_state.st    = cotp_pkg::ST_GETSEL;
        end
        else
        begin
          if (is_tos)
          begin
            nxt_state.rem = len;
            if (dr)
            begin
              // pre-decrement before the push
              nxt_state.asp  = state_ff.asp - {24'h00_0000, step};
              nxt_state.addr = state_ff.asp - {24'h00_0000, step};
            end
          end
          nxt_state.st = cotp_pkg::ST_FETCH;
        end
      end
      cotp_pkg::ST_GETADR:
      begin
        if (state_ff.req && bus_ack_i)
        begin
          nxt_state.req  = 1'b0;
          nxt_state.addr = bus_rdata_i;
          nxt_state.rem  = len;
          nxt_state.st   = (len == 8'h00) ? cotp_pkg::ST_FINISH : cotp_pkg::ST_FETCH;
        end
      end
      cotp_pkg::ST_GETSEL:
      begin
        if (state_ff.req && bus_ack_i)
        begin
          nxt_state.req = 1'b0;
          nxt_state.st  = cotp_pkg::ST_FETCH;
          // top hex digit is a don't-care
          case (bus_rdata_i[11:0])
            cotp_pkg::SEL_SFC:  nxt_state.csel = 3'h0;
            cotp_pkg::SEL_DFC:  nxt_state.csel = 3'h1;
            cotp_pkg::SEL_CACHE_CONTROL_REG: nxt_state.csel = 3'h2;
            cotp_pkg::SEL_USP:  nxt_state.csel = 3'h3;
            cotp_pkg::SEL_VBR:  nxt_state.csel = 3'h4;
            cotp_pkg::SEL_CACHE_ADDRESS_REG: nxt_state.csel = 3'h5;
            cotp_pkg::SEL_MSP:  nxt_state.csel = 3'h6;
            cotp_pkg::SEL_ISP:  nxt_state.csel = 3'h7;
            default:
            begin
              nxt_state.viol = 1'b1;
              nxt_state.st   = cotp_pkg::ST_IDLE;
            end
          endcase
        end
      end
      cotp_pkg::ST_FETCH:
      begin
        rf_addr = {state_ff.prim[cotp_pkg::PRIM_DA_BIT], state_ff.prim[2:0]};
        if (!state_ff.pend)
        begin
          if (dr || is_take || is_tos)
          begin
            // source is the operand register (toward main) or memory (toward coprocessor)
            nxt_state.req   = 1'b1;
            nxt_state.we    = 1'b0;
            nxt_state.size  = part;
            nxt_state.baddr = dr ? (CIR_BASE + cotp_pkg::CIR_OPERAND) : state_ff.addr;
            nxt_state.fc    = dr ? cotp_pkg::FC_CPU_SPACE : dfc;
            nxt_state.pend  = 1'b1;
          end
          else if (is_sreg && !sreg_asp)
          begin
            nxt_state.pend = 1'b1;
          end
          else
          begin
            nxt_state.hold = is_sreg ? state_ff.asp : state_ff.ctrl[state_ff.csel];
            nxt_state.st   = cotp_pkg::ST_STORE;
          end
        end
        else if (state_ff.req)
        begin
          if (bus_ack_i)
          begin
            nxt_state.req  = 1'b0;
            nxt_state.pend = 1'b0;
            nxt_state.hold = bus_rdata_i;
            nxt_state.st   = cotp_pkg::ST_STORE;
          end
        end
        else
        begin
          nxt_state.pend = 1'b0;
          nxt_state.hold = rf_rdata;
          nxt_state.st   = cotp_pkg::ST_STORE;
        end
      end
      cotp_pkg::ST_STORE:
      begin
        rf_addr  = {state_ff.prim[cotp_pkg::PRIM_DA_BIT], state_ff.prim[2:0]};
        rf_wdata = state_ff.hold;
        if (!state_ff.pend && (!dr || is_take || is_tos))
        begin
          nxt_state.req   = 1'b1;
          nxt_state.we    = 1'b1;
          nxt_state.size  = part;
          nxt_state.wdata = state_ff.hold;
          nxt_state.baddr = dr ? state_ff.addr : (CIR_BASE + cotp_pkg::CIR_OPERAND);
          nxt_state.fc    = dr ? dfc : cotp_pkg::FC_CPU_SPACE;
          nxt_state.pend  = 1'b1;
        end
        else if (!state_ff.pend || (state_ff.req && bus_ack_i))
        begin
          if (!state_ff.pend && is_sreg)
          begin
            rf_we = ~sreg_asp;
            if (sreg_asp)
            begin
              nxt_state.asp = state_ff.hold;
            end
          end
          else if (!state_ff.pend)
          begin
            nxt_state.ctrl[state_ff.csel] = state_ff.hold;
          end
          nxt_state.req  = 1'b0;
          nxt_state.pend = 1'b0;
          nxt_state.rem  = state_ff.rem - {5'h00, part};
          nxt_state.addr = state_ff.addr + {29'h0000_0000, part};
          nxt_state.st   = (state_ff.rem == {5'h00, part}) ? cotp_pkg::ST_FINISH : cotp_pkg::ST_FETCH;
        end
      end
      cotp_pkg::ST_FINISH:
      begin
        if (is_tos && !dr)
        begin
          // post-increment after the pop
          nxt_state.asp = state_ff.asp + {24'h00_0000, step};
        end
        nxt_state.done = 1'b1;
        nxt_state.st   = cotp_pkg::ST_IDLE;
      end
      default:
      begin
        nxt_state.st = cotp_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // state register and outputs
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_ff    <= '0;
      state_ff.st <= cotp_pkg::ST_IDLE;
      state_ff.sr <= cotp_pkg::SR_RST;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign wb_ack_o    = state_ff.wb_ack;
  assign wb_dat_o    = state_ff.rd_rf ? rf_rdata : state_ff.wb_dat;
  assign bus_req_o   = state_ff.req;
  assign bus_we_o    = state_ff.we;
  assign bus_addr_o  = state_ff.baddr;
  assign bus_size_o  = state_ff.size;
  assign bus_fc_o    = state_ff.fc;
  assign bus_wdata_o = state_ff.wdata;

endmodule

`default_nettype wire

// >>> verification/cotp_chk.sv
// port assertions for the operand transfer engine
`default_nettype none
module cotp_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_ack_o,
  input wire logic        bus_req_o,
  input wire logic        bus_we_o,
  input wire logic [31:0] bus_addr_o,
  input wire logic [2:0]  bus_size_o,
  input wire logic [2:0]  bus_fc_o,
  input wire logic        bus_ack_i
);
  timeunit 1ns / 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_wait; bus_req_o && !bus_ack_i; endsequence
  sequence s_end; bus_req_o && bus_ack_i; endsequence
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
  AST_REQ_HOLD: assert property (s_wait |=> bus_req_o && $stable(bus_addr_o)) else $error("request moved");
  AST_REQ_END: assert property (s_end |=> !bus_req_o) else $error("request kept after ack");
  AST_FC: assert property (bus_req_o |-> bus_fc_o inside {3'h1, 3'h5, 3'h7}) else $error("bad fc");
  AST_SIZE: assert property (bus_req_o |-> bus_size_o inside {[3'h1:3'h4]}) else $error("bad size");
  AST_CIR: assert property (bus_req_o && bus_fc_o == 3'h7 |-> bus_addr_o inside {32'h10, 32'h14, 32'h18})
    else $error("bad interface address");
  AST_OPADR: assert property (bus_req_o && bus_fc_o == 3'h7 && bus_addr_o == 32'h18 |-> bus_size_o == 3'h4)
    else $error("operand address not a long read");
  AST_REGSEL: assert property (bus_req_o && bus_fc_o == 3'h7 && bus_addr_o == 32'h14 |-> !bus_we_o)
    else $error("register select written");
endmodule
bind cotp_engine cotp_chk chk_u (.clk_i, .rst_i, .wb_ack_o, .bus_req_o, .bus_we_o, .bus_addr_o, .bus_size_o,
  .bus_fc_o, .bus_ack_i);
`default_nettype wire

// >>> verification/cotp_cop_model.sv
// far-side coprocessor and memory answering the engine bus
`default_nettype none
module cotp_cop_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [2:0]  fc_i,
  input  wire logic [2:0]  size_i,
  input  wire logic [31:0] wd_i,
  input  wire logic [31:0] rdv_i,
  output logic             ack_o,
  output logic      [31:0] rd_o,
  output logic      [31:0] wr_o,
  output logic      [31:0] madr_o,
  output logic      [5:0]  mkind_o
);
  timeunit 1ns / 1ns;
  logic [1:0] cnt;
  // released lines show the inverse, never a stale copy
  assign rd_o = ack_o ? rdv_i : ~rdv_i;
  always_ff @(posedge clk_i)
  begin
    ack_o <= 1'b0;
    // wait varies with address: prompt and slow answers both occur
    if (rst_i || !req_i || ack_o)
      cnt <= 2'h0;
    else if (cnt == adr_i[3:2])
      ack_o <= 1'b1;
    else
      cnt <= cnt + 2'h1;
    if (req_i && ack_o && we_i)
      wr_o <= wd_i;
    if (req_i && ack_o && fc_i != 3'h7)
      madr_o <= adr_i;
    if (req_i && ack_o && fc_i != 3'h7)
      mkind_o <= {fc_i, size_i};
  end
endmodule
`default_nettype wire

// >>> verification/tb_coproc_operand_transfer_primitives.sv
// self-checking bench for the operand transfer engine
`default_nettype none
module tb_coproc_operand_transfer_primitives;
  timeunit 1ns / 1ns;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, rdv = 32'h0;
  logic [31:0] wb_dat_o, bus_addr_o, bus_wdata_o, bus_rdata_i, wr, ma, q;
  logic [2:0]  bus_size_o, bus_fc_o;
  logic [5:0]  mk;
  logic        wb_ack_o, bus_req_o, bus_we_o, bus_ack_i;
  int          err_total = 0, checked = 0;
  always #50 clk_i = ~clk_i;
  cotp_engine dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .bus_req_o, .bus_we_o, .bus_addr_o, .bus_size_o, .bus_fc_o, .bus_wdata_o, .bus_rdata_i, .bus_ack_i);
  cotp_cop_model cop_u (.clk_i, .rst_i, .req_i(bus_req_o), .we_i(bus_we_o), .adr_i(bus_addr_o), .fc_i(bus_fc_o),
    .size_i(bus_size_o), .wd_i(bus_wdata_o), .rdv_i(rdv), .ack_o(bus_ack_i), .rd_o(bus_rdata_i), .wr_o(wr),
    .madr_o(ma), .mkind_o(mk));
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    if (g !== e)
      err_total++;
  endtask
  // one classic cycle, held until ack is seen
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // polls status: engine time depends on far-side waits
  task automatic run(input logic [15:0] p, input logic [1:0] c, input logic [2:0] e);
    wb(1'b1, 8'h00, {16'h0, p});
    wb(1'b1, 8'h04, {30'h0, c});
    q = 32'h0;
    while (q[2:1] === 2'b00)
      wb(1'b0, 8'h08, 32'h0);
    chk({29'h0, q[2:0]}, {29'h0, e});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reg();
    wb(1'b1, 8'h48, 32'hA5A5_0F0F);
    run(16'h0C02, 2'h1, 3'b010);
    chk(wr, 32'hA5A5_0F0F);
    rdv <= 32'h1234_5678;
    run(16'h2C0B, 2'h1, 3'b010);
    wb(1'b0, 8'h6C, 32'h0);
    chk(q, 32'h1234_5678);
    run(16'h0C02, 2'h3, 3'b100);
    run(16'h8C02, 2'h3, 3'b010);
    run(16'h0E03, 2'h1, 3'b100);
  endtask
  task automatic t_ctl();
    logic [11:0] code [8] = '{12'h000, 12'h001, 12'h002, 12'h800, 12'h801, 12'h802, 12'h803, 12'h804};
    for (int i = 0; i < 8; i++)
    begin
      rdv <= {20'h0, code[i]};
      run(16'h2D00, 2'h1, 3'b010);
      wb(1'b0, 8'h20 + 8'(4 * i), 32'h0);
      chk(q, {20'h0, code[i]});
    end
    rdv <= 32'hF801;
    run(16'h0D00, 2'h1, 3'b010);
    chk(wr, 32'h0801);
    rdv <= 32'h0805;
    run(16'h0D00, 2'h1, 3'b100);
  endtask
  task automatic t_tos();
    wb(1'b1, 8'h10, 32'h100);
    run(16'h0E01, 2'h1, 3'b010);
    wb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h102);
    run(16'h2E01, 2'h1, 3'b010);
    chk(ma, 32'h100);
    run(16'h0C0F, 2'h1, 3'b010);
    chk(wr, 32'h100);
  endtask
  task automatic t_take();
    rdv <= 32'h1000;
    run(16'h0505, 2'h1, 3'b010);
    chk(ma, 32'h1004);
    chk({26'h0, mk}, 32'h29);
    wb(1'b1, 8'h0C, 32'h0);
    run(16'h25FF, 2'h1, 3'b010);
    chk(ma, 32'h10FC);
    chk({26'h0, mk}, 32'h0B);
    rdv <= 32'h2000;
    run(16'h0500, 2'h1, 3'b010);
    chk(ma, 32'h10FC);
  endtask
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reg();
    t_ctl();
    t_tos();
    t_take();
    summarize();
  end
  // far beyond the roughly one thousand cycles the tests need
  initial
  begin
    repeat (30000) @(posedge clk_i);
    err_total++;
    summarize();
  end
endmodule
`default_nettype wire
